// >>> ssic_chk.sv
`timescale 1ns/1ns
`default_nettype none
module ssic_chk (
  input wire logic        CLK_IN,
  input wire logic        RST_B_IN,
  input wire logic        SCL_IN,
  input wire logic        SDA_OE_OUT,
  input wire logic [12:0] SWEEP_FACTOR_OUT,
  input wire logic [2:0]  SPREAD_AMOUNT_CODE_OUT,
  input wire logic        SPREAD_POWER_OUT,
  input wire logic        SPREAD_FORCE_LOW_OUT,
  input wire logic [6:0]  READBACK_LENGTH_FIELD_OUT,
  input wire logic        OSC_ENABLE_OUT,
  input wire logic        DIFF_ENABLE_OUT,
  input wire logic        SINGLE_ENABLE_OUT,
  input wire logic        CLOCK_PIN_B_PICKED_OUT
);
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RST_B_IN);
  a_power_on_amount: assert property (SPREAD_POWER_OUT == (SPREAD_AMOUNT_CODE_OUT != 3'h0))
    else $error("spread power does not follow amount");
  a_force_low_bypass: assert property (SPREAD_FORCE_LOW_OUT == (SPREAD_AMOUNT_CODE_OUT == 3'h0))
    else $error("spread force low does not follow amount");
  a_length_not_zero: assert property (READBACK_LENGTH_FIELD_OUT != 7'h00)
    else $error("readback length is zero");
  a_one_input_mode: assert property ($onehot({OSC_ENABLE_OUT, DIFF_ENABLE_OUT, SINGLE_ENABLE_OUT}))
    else $error("input stage mode not one hot");
  a_pick_only_single: assert property (CLOCK_PIN_B_PICKED_OUT |-> SINGLE_ENABLE_OUT)
    else $error("pin b picked outside single ended mode");
  a_sweep_in_table: assert property ((SWEEP_FACTOR_OUT == 13'hCD6) || (SWEEP_FACTOR_OUT != 13'hCC4
    && SWEEP_FACTOR_OUT >= 13'h67C && SWEEP_FACTOR_OUT <= 13'h1630
    && (13'h1630 - SWEEP_FACTOR_OUT) % 13'h10C == 13'h0))
    else $error("sweep factor outside table");
  a_sweep_moves_low: assert property ($changed(SWEEP_FACTOR_OUT) |-> !SCL_IN)
    else $error("sweep factor changed with serial clock high");
  a_amount_moves_low: assert property ($changed(SPREAD_AMOUNT_CODE_OUT) |-> !SCL_IN)
    else $error("amount changed with serial clock high");
  a_data_stable_high: assert property (SCL_IN && $past(SCL_IN) |-> $stable(SDA_OE_OUT))
    else $error("data line moved while serial clock high");
  c_spread_on: cover property (SPREAD_POWER_OUT);
  c_pin_b: cover property (CLOCK_PIN_B_PICKED_OUT);
  c_diff: cover property (DIFF_ENABLE_OUT);
endmodule // ssic_chk

bind ssic_config ssic_chk chk (.CLK_IN, .RST_B_IN, .SCL_IN, .SDA_OE_OUT, .SWEEP_FACTOR_OUT, .SPREAD_AMOUNT_CODE_OUT,
  .SPREAD_POWER_OUT, .SPREAD_FORCE_LOW_OUT, .READBACK_LENGTH_FIELD_OUT, .OSC_ENABLE_OUT, .DIFF_ENABLE_OUT,
  .SINGLE_ENABLE_OUT, .CLOCK_PIN_B_PICKED_OUT);
`default_nettype wire

// >>> ssic_config.v
// What this block does
// R1 - Sweep code maps to factor, default 3286
// R2 - Sweep rate is VCO divided by factor
// R3 - Host bypasses loop before changing sweep code
// R4 - Amount code selects center or down spread
// R5 - Amount resets to zero, spread bypassed
// R6 - Host bypasses loop before changing amount
// R7 - Bypass powers spread down, forces output low
// R8 - Block read length 1..127, default 27
// R9 - Input source field at bits 7:6
// R10 - Reset input stage runs as crystal oscillator
// R11 - Single-ended mode: internal bit picks input
// R12 - Bits 1:0 may make pin a select
// R13 - Differential mode ignores single-ended selection
// R14 - Source codes: crystal, single, differential, reserved
// R15 - Pick 0 first input; ignored otherwise
`timescale 1ns/1ns
`default_nettype none
`include "ssic_defs.vh"
module ssic_config
#(
  parameter [6:0] DEVICE_ADDRESS = 7'h69
)
(
  input  wire        CLK_IN,
  input  wire        RST_B_IN,
  input  wire        SCL_IN,
  input  wire        SDA_IN,
  output reg         SDA_OUT,
  output reg         SDA_OE_OUT,
  input  wire        MULTI_FUNCTION_INPUT_A_IN,
  output reg  [12:0] SWEEP_FACTOR_OUT,
  output reg  [2:0]  SPREAD_AMOUNT_CODE_OUT,
  output reg         SPREAD_POWER_OUT,
  output reg         SPREAD_FORCE_LOW_OUT,
  output reg         LOOP_BYPASS_OUT,
  output reg  [6:0]  READBACK_LENGTH_FIELD_OUT,
  output reg         OSC_ENABLE_OUT,
  output reg         DIFF_ENABLE_OUT,
  output reg         SINGLE_ENABLE_OUT,
  output reg         CLOCK_PIN_B_PICKED_OUT
);
  ////////////////////////////////////////////////////////////////////////////
  // Bus state machine encoding.
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_RX   = 5'h02;
  localparam [4:0] ST_ACK  = 5'h04;
  localparam [4:0] ST_TX   = 5'h08;
  localparam [4:0] ST_MACK = 5'h10;
  localparam [1:0] KIND_ADDR = 2'h0;
  localparam [1:0] KIND_CMD  = 2'h1;
  localparam [1:0] KIND_DATA = 2'h2;
  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation.
  wire [2:0] pins_sync;
  reg        scl_prev;
  reg        sda_prev;
  ssic_sync #(.WIDTH(3), .RESET_VAL(1'b1)) u_sync
  (
    .clk_in   (CLK_IN),
    .rst_b_in (RST_B_IN),
    .async_in ({MULTI_FUNCTION_INPUT_A_IN, SDA_IN, SCL_IN}),
    .sync_out (pins_sync)
  );
  wire scl      = pins_sync[0];
  wire sda      = pins_sync[1];
  wire pin_pick = pins_sync[2];
  wire scl_rise = scl & ~scl_prev;
  wire scl_fall = ~scl & scl_prev;
  wire bus_start = scl & scl_prev & sda_prev & ~sda;
  wire bus_stop  = scl & scl_prev & ~sda_prev & sda;
  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers.
  reg [7:0] loop_control;
  reg [7:0] input_pick;
  reg [7:0] input_source;
  reg [7:0] spread_control;
  reg [7:0] block_read_length;
  reg [4:0] state;
  reg [1:0] rx_kind;
  reg [3:0] bit_cnt;
  reg [7:0] shift;
  reg [7:0] pointer;
  reg       read_dir;
  reg       first_read;
  reg [6:0] bytes_left;
  function [12:0] sweep_factor;
    input [3:0] code;
    begin
      case (code)
        4'h0:    sweep_factor = 13'h1630;
        4'h1:    sweep_factor = 13'h1524;
        4'h2:    sweep_factor = 13'h1418;
        4'h3:    sweep_factor = 13'h130C;
        4'h4:    sweep_factor = 13'h1200;
        4'h5:    sweep_factor = 13'h10F4;
        4'h6:    sweep_factor = 13'h0FE8;
        4'h7:    sweep_factor = 13'h0EDC;
        4'h8:    sweep_factor = 13'h0DD0;
        4'h9:    sweep_factor = 13'h0CD6;
        4'hA:    sweep_factor = 13'h0BB8;
        4'hB:    sweep_factor = 13'h0AAC;
        4'hC:    sweep_factor = 13'h09A0;
        4'hD:    sweep_factor = 13'h0894;
        4'hE:    sweep_factor = 13'h0788;
        default: sweep_factor = 13'h067C;
      endcase
    end
  endfunction
  // Register readback; unmapped offsets read as zero.
  function [7:0] reg_read;
    input [7:0] ofs;
    begin
      case (ofs)
        `SSIC_OFS_LOOP_CONTROL:      reg_read = loop_control;
        `SSIC_OFS_INPUT_PICK:        reg_read = input_pick;
        `SSIC_OFS_INPUT_SOURCE:      reg_read = input_source;
        `SSIC_OFS_SPREAD_CONTROL:    reg_read = spread_control;
        `SSIC_OFS_BLOCK_READ_LENGTH: reg_read = block_read_length;
        default:                     reg_read = 8'h00;
      endcase
    end
  endfunction
  wire [7:0] rx_byte  = shift;
  wire       wr_fire  = (state == ST_RX) && scl_fall && (bit_cnt == 4'h8) && (rx_kind == KIND_DATA);
  wire [7:0] next_tx  = first_read ? {1'b0, block_read_length[`SSIC_MSB_LENGTH:`SSIC_LSB_LENGTH]} :
                        (bytes_left != 7'h00) ? reg_read(pointer) : `SSIC_IDLE_BYTE; // [R8]
  always @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      loop_control      <= `SSIC_RST_LOOP_CONTROL;
      input_pick        <= `SSIC_RST_INPUT_PICK;
      input_source      <= `SSIC_RST_INPUT_SOURCE; // [R10]
      spread_control    <= `SSIC_RST_SPREAD_CONTROL; // [R1] [R5]
      block_read_length <= `SSIC_RST_BLOCK_READ_LENGTH; // [R8]
    end
    else if (wr_fire)
    begin
      case (pointer)
        `SSIC_OFS_LOOP_CONTROL:   loop_control   <= rx_byte;
        `SSIC_OFS_INPUT_PICK:     input_pick     <= rx_byte;
        `SSIC_OFS_INPUT_SOURCE:   input_source   <= rx_byte; // [R9]
        `SSIC_OFS_SPREAD_CONTROL: spread_control <= rx_byte; // [R4]
        `SSIC_OFS_BLOCK_READ_LENGTH:
        begin
          // A zero length is refused and the previous length kept.
          if (rx_byte[`SSIC_MSB_LENGTH:`SSIC_LSB_LENGTH] != 7'h00)
            block_read_length <= rx_byte; // [R8]
        end
        default: ;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // SMBus slave: byte writes with auto-increment, block read with count.
  always @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      scl_prev   <= 1'b1;
      sda_prev   <= 1'b1;
      state      <= ST_IDLE;
      rx_kind    <= KIND_ADDR;
      bit_cnt    <= 4'h0;
      shift      <= 8'h00;
      pointer    <= 8'h00;
      read_dir   <= 1'b0;
      first_read <= 1'b0;
      bytes_left <= 7'h00;
      SDA_OUT    <= 1'b0;
      SDA_OE_OUT <= 1'b0;
    end
    else
    begin
      scl_prev <= scl;
      sda_prev <= sda;
      SDA_OUT  <= 1'b0;
      if (bus_stop)
      begin
        state      <= ST_IDLE;
        SDA_OE_OUT <= 1'b0;
      end
      else if (bus_start)
      begin
        state      <= ST_RX;
        rx_kind    <= KIND_ADDR;
        bit_cnt    <= 4'h0;
        SDA_OE_OUT <= 1'b0;
      end
      else
      begin
        case (state)
          ST_IDLE: ;
          ST_RX:
          begin
            if (scl_rise)
            begin
              shift   <= {shift[6:0], sda};
              bit_cnt <= bit_cnt + 4'h1;
            end
            else if (scl_fall && (bit_cnt == 4'h8))
            begin
              bit_cnt <= 4'h0;
              case (rx_kind)
                KIND_ADDR:
                begin
                  if (shift[7:1] == DEVICE_ADDRESS)
                  begin
                    read_dir   <= shift[0];
                    first_read <= 1'b1;
                    bytes_left <= block_read_length[`SSIC_MSB_LENGTH:`SSIC_LSB_LENGTH];
                    SDA_OE_OUT <= 1'b1;
                    state      <= ST_ACK;
                  end
                  else
                    state <= ST_IDLE;
                end
                KIND_CMD:
                begin
                  pointer    <= shift;
                  SDA_OE_OUT <= 1'b1;
                  state      <= ST_ACK;
                end
                default:
                begin
                  pointer    <= pointer + 8'h01;
                  SDA_OE_OUT <= 1'b1;
                  state      <= ST_ACK;
                end
              endcase
            end
          end
          ST_ACK:
          begin
            if (scl_fall)
            begin
              bit_cnt <= 4'h0;
              if (read_dir && (rx_kind == KIND_ADDR))
              begin
                shift      <= next_tx;
                SDA_OE_OUT <= ~next_tx[7];
                state      <= ST_TX;
              end
              else
              begin
                SDA_OE_OUT <= 1'b0;
                rx_kind    <= (rx_kind == KIND_ADDR) ? KIND_CMD : KIND_DATA;
                state      <= ST_RX;
              end
            end
          end
          ST_TX:
          begin
            if (scl_fall)
            begin
              if (bit_cnt == 4'h7)
              begin
                SDA_OE_OUT <= 1'b0;
                bit_cnt    <= 4'h0;
                state      <= ST_MACK;
                if (first_read)
                  first_read <= 1'b0;
                else if (bytes_left != 7'h00)
                begin
                  bytes_left <= bytes_left - 7'h01;
                  pointer    <= pointer + 8'h01;
                end
              end
              else
              begin
                bit_cnt    <= bit_cnt + 4'h1;
                shift      <= {shift[6:0], 1'b1};
                SDA_OE_OUT <= ~shift[6];
              end
            end
          end
          ST_MACK:
          begin
            // A not-acknowledge ends the read; the slave waits for stop.
            if (scl_rise && sda)
              state <= ST_IDLE;
            else if (scl_fall)
            begin
              shift      <= next_tx;
              SDA_OE_OUT <= ~next_tx[7];
              state      <= ST_TX;
            end
          end
          default:
          begin
            state      <= ST_IDLE;
            SDA_OE_OUT <= 1'b0;
          end
        endcase
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Decoded controls toward the spread loop and the input stage.
  wire [1:0] source  = input_source[`SSIC_MSB_SOURCE:`SSIC_LSB_SOURCE];
  wire [2:0] amount  = spread_control[`SSIC_MSB_AMOUNT:`SSIC_LSB_AMOUNT];
  wire       pin_sel = (input_pick[`SSIC_MSB_PIN_ROLE:`SSIC_LSB_PIN_ROLE] == `SSIC_ROLE_CLOCK_PICK);
  always @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      SWEEP_FACTOR_OUT          <= 13'h0CD6;
      SPREAD_AMOUNT_CODE_OUT    <= `SSIC_AMOUNT_NONE;
      SPREAD_POWER_OUT          <= 1'b0;
      SPREAD_FORCE_LOW_OUT      <= 1'b1;
      LOOP_BYPASS_OUT           <= 1'b0;
      READBACK_LENGTH_FIELD_OUT <= 7'h1B;
      OSC_ENABLE_OUT            <= 1'b1;
      DIFF_ENABLE_OUT           <= 1'b0;
      SINGLE_ENABLE_OUT         <= 1'b0;
      CLOCK_PIN_B_PICKED_OUT    <= 1'b0;
    end
    else
    begin
      // The modulator divides the VCO clock by this factor to set the sweep rate.
      SWEEP_FACTOR_OUT <= sweep_factor(spread_control[`SSIC_MSB_SWEEP:`SSIC_LSB_SWEEP]); // [R1] [R2]
      SPREAD_AMOUNT_CODE_OUT <= amount; // [R4]
      LOOP_BYPASS_OUT <= loop_control[`SSIC_BIT_LOOP_BYPASS]; // [R3] [R6]
      SPREAD_POWER_OUT     <= (amount != `SSIC_AMOUNT_NONE); // [R5] [R7]
      SPREAD_FORCE_LOW_OUT <= (amount == `SSIC_AMOUNT_NONE); // [R7]
      READBACK_LENGTH_FIELD_OUT <= block_read_length[`SSIC_MSB_LENGTH:`SSIC_LSB_LENGTH]; // [R8]
      // The reserved source code falls back to crystal operation.
      OSC_ENABLE_OUT    <= (source == `SSIC_SRC_CRYSTAL) || (source == 2'h3); // [R10] [R14]
      DIFF_ENABLE_OUT   <= (source == `SSIC_SRC_DIFF); // [R13] [R14]
      SINGLE_ENABLE_OUT <= (source == `SSIC_SRC_SINGLE); // [R9] [R14]
      if (source == `SSIC_SRC_SINGLE)
        CLOCK_PIN_B_PICKED_OUT <= pin_sel ? pin_pick : input_pick[`SSIC_BIT_INTERNAL_PICK]; // [R11] [R12] [R15]
      else
        CLOCK_PIN_B_PICKED_OUT <= 1'b0; // [R13] [R15]
    end
  end
endmodule // ssic_config
`default_nettype wire

// >>> ssic_defs.vh
`ifndef SSIC_DEFS_VH
`define SSIC_DEFS_VH

// Register offsets (SMBus command byte values).
`define SSIC_OFS_LOOP_CONTROL      8'h03
`define SSIC_OFS_INPUT_PICK        8'h0A
`define SSIC_OFS_INPUT_SOURCE      8'h0B
`define SSIC_OFS_SPREAD_CONTROL    8'h19
`define SSIC_OFS_BLOCK_READ_LENGTH 8'h1A

// Reset values.
`define SSIC_RST_LOOP_CONTROL      8'h00
`define SSIC_RST_INPUT_PICK        8'h00
`define SSIC_RST_INPUT_SOURCE      8'h00
`define SSIC_RST_SPREAD_CONTROL    8'h09
`define SSIC_RST_BLOCK_READ_LENGTH 8'h1B

// Field positions.
`define SSIC_BIT_LOOP_BYPASS       6
`define SSIC_BIT_INTERNAL_PICK     4
`define SSIC_MSB_PIN_ROLE          1
`define SSIC_LSB_PIN_ROLE          0
`define SSIC_MSB_SOURCE            7
`define SSIC_LSB_SOURCE            6
`define SSIC_MSB_AMOUNT            6
`define SSIC_LSB_AMOUNT            4
`define SSIC_MSB_SWEEP             3
`define SSIC_LSB_SWEEP             0
`define SSIC_MSB_LENGTH            6
`define SSIC_LSB_LENGTH            0

// Field codes.
`define SSIC_SRC_CRYSTAL           2'h0
`define SSIC_SRC_SINGLE            2'h1
`define SSIC_SRC_DIFF              2'h2
`define SSIC_ROLE_CLOCK_PICK       2'h3
`define SSIC_AMOUNT_NONE           3'h0

// Value sent for bytes read past the programmed block length.
`define SSIC_IDLE_BYTE             8'hFF

`endif

// >>> ssic_host.sv
`timescale 1ns/1ns
`default_nettype none
module ssic_host #(
  parameter logic [6:0] ADDR = 7'h69
) (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output var logic  scl_out,
  output var logic  sda_low_out
);
  // Half period of the serial clock in system cycles; raise it for a slow host.
  int half = 8;
  initial scl_out = 1'b1;
  initial sda_low_out = 1'b0;
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic start_bit();
    sda_low_out = 1'b0;
    tick(half);
    scl_out = 1'b1;
    tick(half);
    sda_low_out = 1'b1;
    tick(half);
    scl_out = 1'b0;
    tick(2);
  endtask
  task automatic stop_bit();
    sda_low_out = 1'b1;
    tick(half);
    scl_out = 1'b1;
    tick(half);
    sda_low_out = 1'b0;
    tick(half);
  endtask
  // Data is held two cycles past the clock fall so it never moves while the clock looks high.
  task automatic clock_bit(input logic b, output logic r);
    sda_low_out = !b;
    tick(half);
    scl_out = 1'b1;
    tick(half);
    r = sda_in;
    scl_out = 1'b0;
    tick(2);
  endtask
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--)
      clock_bit(d[i], q[i]);
    clock_bit(last, ack);
  endtask
  task automatic write_reg(input logic [6:0] a, input logic [7:0] o, input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic [2:0] k;
    start_bit();
    xfer({a, 1'b0}, 1'b1, q, k[0]);
    xfer(o, 1'b1, q, k[1]);
    xfer(d, 1'b1, q, k[2]);
    stop_bit();
    ok = (k == 3'h0);
  endtask
  task automatic read_block(input logic [7:0] o, input int n, output logic [7:0] q[$]);
    logic [7:0] b;
    logic k;
    q = {};
    start_bit();
    xfer({ADDR, 1'b0}, 1'b1, b, k);
    xfer(o, 1'b1, b, k);
    start_bit();
    xfer({ADDR, 1'b1}, 1'b1, b, k);
    for (int i = 0; i <= n; i++)
    begin
      xfer(8'hFF, i == n, b, k);
      q.push_back(b);
    end
    stop_bit();
  endtask
  // The loop is held in bypass while the spread byte changes.
  task automatic set_spread(input logic [7:0] d, output logic ok);
    logic [2:0] k;
    write_reg(ADDR, 8'h03, 8'h40, k[0]);
    write_reg(ADDR, 8'h19, d, k[1]);
    write_reg(ADDR, 8'h03, 8'h00, k[2]);
    ok = &k;
  endtask
endmodule // ssic_host
`default_nettype wire

// >>> ssic_sync.v
`timescale 1ns/1ns
`default_nettype none

module ssic_sync
#(
  parameter WIDTH     = 1,
  parameter RESET_VAL = 1'b1
)
(
  input  wire             clk_in,
  input  wire             rst_b_in,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage;

  always @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      stage    <= {WIDTH{RESET_VAL}};
      sync_out <= {WIDTH{RESET_VAL}};
    end
    else
    begin
      stage    <= async_in;
      sync_out <= stage;
    end
  end

endmodule // ssic_sync

`default_nettype wire

// >>> tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam logic [6:0] ADDR = 7'h69;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        pin = 1'b0;
  logic        scl;
  logic        host_low;
  wire logic   oe;
  wire logic   sda_o;
  wire logic   sda = !(host_low | (oe & !sda_o));
  wire logic [12:0] sweep;
  wire logic [2:0]  amt;
  wire logic [6:0]  len;
  wire logic   pwr, flow, byp, osc, dif, sgl, pkb;
  logic [7:0]  regs [256];
  logic [7:0]  rnd = 8'h56;
  int          n_errors = 0;
  int          n_compared = 0;
  int          cycles = 0;
  ssic_host #(.ADDR(ADDR)) host (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_low_out(host_low));
  ssic_config #(.DEVICE_ADDRESS(ADDR)) dut (.CLK_IN(clk), .RST_B_IN(rst_b), .SCL_IN(scl), .SDA_IN(sda),
    .SDA_OUT(sda_o), .SDA_OE_OUT(oe), .MULTI_FUNCTION_INPUT_A_IN(pin), .SWEEP_FACTOR_OUT(sweep),
    .SPREAD_AMOUNT_CODE_OUT(amt), .SPREAD_POWER_OUT(pwr), .SPREAD_FORCE_LOW_OUT(flow), .LOOP_BYPASS_OUT(byp),
    .READBACK_LENGTH_FIELD_OUT(len), .OSC_ENABLE_OUT(osc), .DIFF_ENABLE_OUT(dif), .SINGLE_ENABLE_OUT(sgl),
    .CLOCK_PIN_B_PICKED_OUT(pkb));
  always #4 clk = !clk;
  ////////////////////////////////////////
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [29:0] expect_outs();
    logic [12:0] c;
    logic [1:0]  s;
    logic [7:0]  p;
    c = {9'h000, regs[8'h19][3:0]};
    s = regs[8'h0B][7:6];
    p = regs[8'h0A];
    return {(c == 13'h9) ? 13'hCD6 : 13'h1630 - 13'h10C * c, regs[8'h19][6:4], regs[8'h19][6:4] != 3'h0,
      regs[8'h19][6:4] == 3'h0, regs[8'h03][6], regs[8'h1A][6:0], s == 2'h0 || s == 2'h3, s == 2'h2,
      s == 2'h1, s == 2'h1 && (p[1:0] == 2'h3 ? pin : p[4])};
  endfunction
  task automatic mwrite(input logic [7:0] o, input logic [7:0] d);
    if (o inside {8'h03, 8'h0A, 8'h0B, 8'h19} || (o == 8'h1A && d[6:0] != 7'h00))
      regs[o] = d;
  endtask
  task automatic check(input logic [29:0] g, input logic [29:0] e);
    n_compared++;
    if (g !== e)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic check_outs();
    check({sweep, amt, pwr, flow, byp, len, osc, dif, sgl, pkb}, expect_outs());
  endtask
  task automatic wr(input logic [7:0] o, input logic [7:0] d);
    logic ok;
    host.write_reg(ADDR, o, d, ok);
    check({29'h0, ok}, 30'h1);
    mwrite(o, d);
  endtask
  task automatic rd(input logic [7:0] o, input int n);
    logic [7:0] q[$];
    host.read_block(o, n, q);
    check(q[0], regs[8'h1A]);
    for (int k = 1; k <= n; k++)
      check(q[k], k <= regs[8'h1A] ? regs[o + k - 1] : 8'hFF);
  endtask
  task automatic conclude();
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 80000)
    begin
      n_errors++;
      conclude();
    end
  end
  ////////////////////////////////////////
  initial
  begin
    logic ok;
    regs = '{default: 8'h00};
    regs[8'h19] = 8'h09;
    regs[8'h1A] = 8'h1B;
    repeat (20) @(posedge clk);
    #1;
    rst_b = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    check_outs();
    rd(8'h19, 2);
    $display("test reset values done");
    for (int i = 0; i < 16; i++)
    begin
      host.half = (i % 8 == 7) ? 24 : 8;
      host.set_spread({1'b0, i[2:0], i[3:0]}, ok);
      check({29'h0, ok}, 30'h1);
      mwrite(8'h19, {1'b0, i[2:0], i[3:0]});
      check_outs();
    end
    host.half = 8;
    $display("test spread codes done");
    wr(8'h1A, 8'h00);
    check_outs();
    wr(8'h1A, 8'h7F);
    check_outs();
    wr(8'h1A, 8'h02);
    rd(8'h0A, 4);
    wr(8'h05, 8'h33);
    rd(8'h04, 2);
    host.write_reg(ADDR ^ 7'h01, 8'h19, 8'h77, ok);
    check({29'h0, ok}, 30'h0);
    check_outs();
    $display("test block length done");
    for (int i = 0; i < 16; i++)
    begin
      rnd = lfsr(rnd);
      wr(8'h0B, {i[1:0], 6'h00});
      wr(8'h0A, rnd & 8'h13);
      wr(8'h03, rnd & 8'h40);
      pin = rnd[7];
      repeat (8) @(posedge clk);
      #1;
      check_outs();
      pin = !pin;
      repeat (8) @(posedge clk);
      #1;
      check_outs();
    end
    $display("test input select done");
    conclude();
  end
endmodule // tb
`default_nettype wire
